// File: logic/imrc_pkg.sv
// Shared constants for the idle mode and reset control block
package imrc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TRAP_SEL = 8'h04;
  localparam logic [7:0] OFS_TRAP_KEY = 8'h08;
  localparam logic [7:0] OFS_INT_EN   = 8'h0C;
  localparam logic [7:0] OFS_LATCH    = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_CORE     = 8'h18;

  // system_control_two fields
  localparam int         CTRL_HF_RUN_BIT  = 7;
  localparam int         CTRL_CLK_SEL_BIT = 6;
  localparam int         CTRL_IDLE_BIT    = 5;

  // Interrupt enable register fields
  localparam int         INT_MASTER_BIT   = 31;

  // Core flag register fields
  localparam int         CORE_BANK_LSB    = 0;
  localparam int         CORE_JUMP_BIT    = 4;
  localparam int         CORE_NEST_BIT    = 5;
  localparam int         CORE_WDT_EN_BIT  = 6;

  // Status register fields
  localparam int         STAT_IDLE_BIT    = 0;
  localparam int         STAT_CAUSE_LSB   = 4;

  // Reset cause codes
  localparam int         CAUSE_TRAP       = 0;
  localparam int         CAUSE_WDT        = 1;
  localparam int         CAUSE_CLOCK      = 2;

  // Reset values
  localparam logic       HF_RUN_RESET     = 1'b1;
  localparam logic       CLK_SEL_RESET    = 1'b0;
  localparam logic       JUMP_FLAG_RESET  = 1'b1;
  localparam logic       WDT_EN_RESET     = 1'b1;
  localparam logic [3:0] BANK_SEL_RESET   = 4'h0;

  // Reset vector and trap area
  localparam logic [19:0] RESET_VECTOR    = 20'hFFFFC;
  localparam logic [19:0] VECTOR_LAST     = 20'hFFFFE;
  localparam logic [19:0] TRAP_AREA_LO    = 20'h00000;
  localparam logic [19:0] TRAP_AREA_HI    = 20'h00FFF;
  localparam logic [7:0]  TRAP_KEY_VALUE  = 8'hA5;

  // Timing: reset length of 12 oscillator clocks at 25 MHz
  localparam int MCLK_PERIOD_NS  = 40;
  localparam int RST_MIN_NS      = 480;
  localparam int RST_HOLD_CYCLES = (RST_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  typedef enum logic [1:0] {
    IMRC_ST_RUN  = 2'b00,
    IMRC_ST_IDLE = 2'b01
  } imrc_state_t;

endpackage

// File: logic/imrc_rst_stretch.sv
// Stretches an internal reset request to a minimum length
`timescale 1ns/1ps
module imrc_rst_stretch #(
  parameter int HOLD = 12
) (
  // Clock and pin reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Request and stretched reset
  input  wire logic req,
  output logic      active_q
);
  localparam int CW = $clog2(HOLD + 1);

  logic [CW-1:0] cnt_q;

  // Cleared by the pin reset only, never assumed clear at power-up
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q    <= '0;
      active_q <= 1'b0;
    end
    else if (req)
    begin
      cnt_q    <= CW'(HOLD - 1);
      active_q <= 1'b1;
    end
    else
    begin
      if (cnt_q != '0)
        cnt_q <= cnt_q - CW'(1);
      active_q <= (cnt_q != '0);
    end
  end
endmodule

// File: logic/imrc_trap_det.sv
// Flags instruction fetches that land in the trap area
`timescale 1ns/1ps
module imrc_trap_det #(
  parameter logic [19:0] LO = 20'h00000,
  parameter logic [19:0] HI = 20'h00FFF
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Fetch monitor
  input  wire logic        allowed,
  input  wire logic        fetch_valid,
  input  wire logic [19:0] fetch_addr,
  // Trap request
  output logic             hit_q
);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      hit_q <= 1'b0;
    else
      hit_q <= allowed && fetch_valid && (fetch_addr >= LO) && (fetch_addr <= HI);
  end
endmodule

// File: logic/imrc_top.sv
// Idle mode and reset control with Avalon-MM register access
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module imrc_top #(
  parameter int          NIRQ    = 16,
  parameter int          HOLD    = imrc_pkg::RST_HOLD_CYCLES,
  parameter logic [19:0] TRAP_LO = imrc_pkg::TRAP_AREA_LO,
  parameter logic [19:0] TRAP_HI = imrc_pkg::TRAP_AREA_HI
) (
  // Clock and reset pin
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic [31:0]          avs_readdata,
  output logic                 avs_waitrequest,
  // CPU side
  input  wire logic            fetch_valid,
  input  wire logic [19:0]     fetch_addr,
  input  wire logic [19:0]     resume_pc,
  input  wire logic [NIRQ-1:0] irq_set,
  input  wire logic [NIRQ-1:0] irq_ack,
  input  wire logic            wdt_reset_req,
  output logic                 core_reset_n_q,
  output logic                 pc_load_q,
  output logic [19:0]          pc_value_q,
  output logic                 cpu_halt_q,
  output logic                 wdt_halt_q,
  output logic                 service_req_q,
  // Flag state
  output logic                 interrupt_master_enable_flag_q,
  output logic [NIRQ-1:0]      individual_interrupt_enable_q,
  output logic [NIRQ-1:0]      interrupt_request_latch_q,
  output logic                 jump_status_flag_q,
  output logic [3:0]           register_bank_selector_q,
  output logic                 interrupt_nesting_flag_q,
  output logic                 wdt_enable_q,
  output logic [7:0]           prescaler_q
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  imrc_pkg::imrc_state_t st_q;
  imrc_pkg::imrc_state_t st_d;
  logic                  hf_oscillator_run_q;
  logic                  system_clock_select_q;
  logic                  trap_enable_select_q;
  logic                  trap_unlock_key_ok_q;
  logic [2:0]            rst_cause_q;
  logic                  trap_hit;
  logic                  clk_fault;
  logic                  int_req;
  logic                  int_act;
  logic                  wr_take;
  logic                  wake;
  logic                  trap_allowed;
  logic [31:0]           rd_value;

  // Bus handshake
  assign wr_take   = avs_write && !avs_waitrequest;
  assign clk_fault = !hf_oscillator_run_q || system_clock_select_q;
  assign wake      = |(interrupt_request_latch_q & individual_interrupt_enable_q);
  // Trap stays allowed unless both control registers agree on prohibit
  assign trap_allowed = !(trap_enable_select_q && trap_unlock_key_ok_q);
  assign int_req   = trap_hit || wdt_reset_req || clk_fault;

  imrc_trap_det #(
    .LO (TRAP_LO),
    .HI (TRAP_HI)
  ) u_trap (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .allowed     (trap_allowed),
    .fetch_valid (fetch_valid),
    .fetch_addr  (fetch_addr),
    .hit_q       (trap_hit)
  );

  // Internal reset length; no power-on state assumed
  imrc_rst_stretch #(
    .HOLD (HOLD)
  ) u_stretch (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .req      (int_req),
    .active_q (int_act)
  );

  // One wait state, then one cycle of answer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  always_comb
  begin
    rd_value = 32'h0000_0000;
    if (hit(avs_address, imrc_pkg::OFS_CTRL))
    begin
      rd_value[imrc_pkg::CTRL_HF_RUN_BIT]  = hf_oscillator_run_q;
      rd_value[imrc_pkg::CTRL_CLK_SEL_BIT] = system_clock_select_q;
      rd_value[imrc_pkg::CTRL_IDLE_BIT]    = (st_q == imrc_pkg::IMRC_ST_IDLE);
    end
    else if (hit(avs_address, imrc_pkg::OFS_INT_EN))
    begin
      rd_value[NIRQ-1:0]                   = individual_interrupt_enable_q;
      rd_value[imrc_pkg::INT_MASTER_BIT]   = interrupt_master_enable_flag_q;
    end
    else if (hit(avs_address, imrc_pkg::OFS_LATCH))
      rd_value[NIRQ-1:0] = interrupt_request_latch_q;
    else if (hit(avs_address, imrc_pkg::OFS_STATUS))
    begin
      rd_value[imrc_pkg::STAT_IDLE_BIT]    = (st_q == imrc_pkg::IMRC_ST_IDLE);
      rd_value[imrc_pkg::STAT_CAUSE_LSB +: 3] = rst_cause_q;
    end
    else if (hit(avs_address, imrc_pkg::OFS_CORE))
    begin
      rd_value[imrc_pkg::CORE_BANK_LSB +: 4] = register_bank_selector_q;
      rd_value[imrc_pkg::CORE_JUMP_BIT]      = jump_status_flag_q;
      rd_value[imrc_pkg::CORE_NEST_BIT]      = interrupt_nesting_flag_q;
      rd_value[imrc_pkg::CORE_WDT_EN_BIT]    = wdt_enable_q;
    end
    // Trap registers read as zero: write-only
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= rd_value;
  end

  // Idle sequencing
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      imrc_pkg::IMRC_ST_RUN:
        if (wr_take && hit(avs_address, imrc_pkg::OFS_CTRL)
            && avs_writedata[imrc_pkg::CTRL_IDLE_BIT])
          st_d = imrc_pkg::IMRC_ST_IDLE;
      imrc_pkg::IMRC_ST_IDLE:
        if (wake)
          st_d = imrc_pkg::IMRC_ST_RUN;
      default:
        st_d = imrc_pkg::IMRC_ST_RUN;
    endcase
  end

  // Pin reset ends idle at once and restarts in run
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= imrc_pkg::IMRC_ST_RUN;
      cpu_halt_q <= 1'b0;
      wdt_halt_q <= 1'b0;
    end
    else if (int_act)
    begin
      st_q       <= imrc_pkg::IMRC_ST_RUN;
      cpu_halt_q <= 1'b0;
      wdt_halt_q <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      cpu_halt_q <= (st_d == imrc_pkg::IMRC_ST_IDLE);
      wdt_halt_q <= (st_d == imrc_pkg::IMRC_ST_IDLE);
    end
  end

  // Service request only when master enable is set
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      service_req_q <= 1'b0;
    else
      service_req_q <= !int_act && (st_q == imrc_pkg::IMRC_ST_IDLE) && wake
                       && interrupt_master_enable_flag_q;
  end

  // Reset hold and vector load
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reset_n_q <= 1'b0;
      pc_load_q      <= 1'b0;
      pc_value_q     <= imrc_pkg::RESET_VECTOR;
    end
    else
    begin
      core_reset_n_q <= !int_act && !int_req;
      pc_load_q      <= !core_reset_n_q && !int_act && !int_req;
      if (!core_reset_n_q)
        pc_value_q <= imrc_pkg::RESET_VECTOR;
      else if (st_q == imrc_pkg::IMRC_ST_RUN && st_d == imrc_pkg::IMRC_ST_IDLE)
        pc_value_q <= resume_pc;
    end
  end

  // Control register and trap control
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hf_oscillator_run_q   <= imrc_pkg::HF_RUN_RESET;
      system_clock_select_q <= imrc_pkg::CLK_SEL_RESET;
      trap_enable_select_q  <= 1'b0;
      trap_unlock_key_ok_q  <= 1'b0;
    end
    else if (int_act)
    begin
      hf_oscillator_run_q   <= imrc_pkg::HF_RUN_RESET;
      system_clock_select_q <= imrc_pkg::CLK_SEL_RESET;
      trap_enable_select_q  <= 1'b0;
      trap_unlock_key_ok_q  <= 1'b0;
    end
    else if (wr_take && st_q != imrc_pkg::IMRC_ST_IDLE)
    begin
      if (hit(avs_address, imrc_pkg::OFS_CTRL))
      begin
        hf_oscillator_run_q   <= avs_writedata[imrc_pkg::CTRL_HF_RUN_BIT];
        system_clock_select_q <= avs_writedata[imrc_pkg::CTRL_CLK_SEL_BIT];
      end
      if (hit(avs_address, imrc_pkg::OFS_TRAP_SEL))
        trap_enable_select_q <= avs_writedata[0];
      if (hit(avs_address, imrc_pkg::OFS_TRAP_KEY))
        trap_unlock_key_ok_q <= (avs_writedata[7:0] == imrc_pkg::TRAP_KEY_VALUE);
    end
  end

  // Interrupt enables and core flags
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interrupt_master_enable_flag_q <= 1'b0;
      individual_interrupt_enable_q  <= '0;
      jump_status_flag_q             <= imrc_pkg::JUMP_FLAG_RESET;
      register_bank_selector_q       <= imrc_pkg::BANK_SEL_RESET;
      interrupt_nesting_flag_q       <= 1'b0;
      wdt_enable_q                   <= imrc_pkg::WDT_EN_RESET;
    end
    else if (int_act)
    begin
      interrupt_master_enable_flag_q <= 1'b0;
      individual_interrupt_enable_q  <= '0;
      jump_status_flag_q             <= imrc_pkg::JUMP_FLAG_RESET;
      register_bank_selector_q       <= imrc_pkg::BANK_SEL_RESET;
      interrupt_nesting_flag_q       <= 1'b0;
      wdt_enable_q                   <= imrc_pkg::WDT_EN_RESET;
    end
    else if (wr_take && st_q != imrc_pkg::IMRC_ST_IDLE)
    begin
      if (hit(avs_address, imrc_pkg::OFS_INT_EN))
      begin
        interrupt_master_enable_flag_q <= avs_writedata[imrc_pkg::INT_MASTER_BIT];
        individual_interrupt_enable_q  <= avs_writedata[NIRQ-1:0];
      end
      if (hit(avs_address, imrc_pkg::OFS_CORE))
      begin
        register_bank_selector_q <= avs_writedata[imrc_pkg::CORE_BANK_LSB +: 4];
        jump_status_flag_q       <= avs_writedata[imrc_pkg::CORE_JUMP_BIT];
        interrupt_nesting_flag_q <= avs_writedata[imrc_pkg::CORE_NEST_BIT];
        wdt_enable_q             <= avs_writedata[imrc_pkg::CORE_WDT_EN_BIT];
      end
    end
  end

  // Latches: a new request wins over a clearing write
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      interrupt_request_latch_q <= '0;
    else if (int_act)
      interrupt_request_latch_q <= '0;
    else if (wr_take && hit(avs_address, imrc_pkg::OFS_LATCH))
      interrupt_request_latch_q <= (interrupt_request_latch_q & avs_writedata[NIRQ-1:0]
                                    & ~irq_ack) | irq_set;
    else
      interrupt_request_latch_q <= (interrupt_request_latch_q & ~irq_ack) | irq_set;
  end

  // Reset cause record, kept across internal resets
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_cause_q <= 3'h0;
    else if (int_req && !int_act)
    begin
      rst_cause_q[imrc_pkg::CAUSE_TRAP]  <= trap_hit;
      rst_cause_q[imrc_pkg::CAUSE_WDT]   <= wdt_reset_req;
      rst_cause_q[imrc_pkg::CAUSE_CLOCK] <= clk_fault;
    end
  end

  // Timing prescaler keeps running through idle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      prescaler_q <= 8'h00;
    else if (int_act)
      prescaler_q <= 8'h00;
    else
      prescaler_q <= prescaler_q + 8'h01;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_idle_halts;
    (st_q == imrc_pkg::IMRC_ST_IDLE) |-> cpu_halt_q && wdt_halt_q && core_reset_n_q;
  endproperty
  a_idle_halts: assert property (p_idle_halts) else $error("idle without halt");

  property p_wake_plain;
    (st_q == imrc_pkg::IMRC_ST_IDLE && wake && !interrupt_master_enable_flag_q && !int_act
     && !int_req)
    |=> (st_q == imrc_pkg::IMRC_ST_RUN) && !service_req_q ##1 !cpu_halt_q;
  endproperty
  a_wake_plain: assert property (p_wake_plain) else $error("plain wake wrong");

  property p_wake_service;
    (st_q == imrc_pkg::IMRC_ST_IDLE && wake && interrupt_master_enable_flag_q && !int_act)
    |=> service_req_q && !cpu_halt_q;
  endproperty
  a_wake_service: assert property (p_wake_service) else $error("no service");

  property p_latch_kept;
    (!wr_take && irq_ack == '0 && !int_act)
    |=> (interrupt_request_latch_q & $past(interrupt_request_latch_q))
        == $past(interrupt_request_latch_q);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch lost");

  property p_clock_reset;
    clk_fault |=> !core_reset_n_q ##2 hf_oscillator_run_q && !system_clock_select_q;
  endproperty
  a_clock_reset: assert property (p_clock_reset) else $error("no clock reset");

  property p_trap_reset;
    (trap_allowed && fetch_valid && fetch_addr >= TRAP_LO && fetch_addr <= TRAP_HI)
    |-> ##2 !core_reset_n_q;
  endproperty
  a_trap_reset: assert property (p_trap_reset) else $error("no trap reset");

  property p_vector;
    pc_load_q |-> pc_value_q == imrc_pkg::RESET_VECTOR && core_reset_n_q && !$past(pc_load_q);
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector load");

  property p_reset_values;
    $rose(core_reset_n_q) |-> jump_status_flag_q && register_bank_selector_q == 4'h0
      && !interrupt_master_enable_flag_q && individual_interrupt_enable_q == '0
      && wdt_enable_q && prescaler_q <= 8'h01;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset values");

  property p_idle_pc;
    (st_q == imrc_pkg::IMRC_ST_IDLE && $past(st_q) == imrc_pkg::IMRC_ST_IDLE)
    |-> $stable(pc_value_q);
  endproperty
  a_idle_pc: assert property (p_idle_pc) else $error("pc moved in idle");

endmodule

// File: dv/imrc_cpu_model.sv
// CPU core model: fetch stream, vector start and interrupt acknowledge
`timescale 1ns/1ps
module imrc_cpu_model #(
  parameter int          NIRQ  = 16,
  parameter logic [19:0] START = 20'h10000
) (
  // Clock
  input  wire logic            mclk,
  // Block outputs
  input  wire logic            core_reset_n,
  input  wire logic            cpu_halt,
  input  wire logic            pc_load,
  input  wire logic            service_req,
  input  wire logic [NIRQ-1:0] pending,
  // Bench jump control
  input  wire logic            jump,
  input  wire logic [19:0]     jump_addr,
  // Fetch and acknowledge
  output logic                 fetch_valid,
  output logic [19:0]          fetch_addr,
  output logic [19:0]          resume_pc,
  output logic [NIRQ-1:0]      irq_ack
);
  logic [19:0] pc_q;

  initial
  begin
    fetch_valid = 1'b0;
    fetch_addr  = 20'h00000;
    irq_ack     = '0;
    pc_q        = START;
  end

  // Fetch address is scrambled while no fetch is offered
  always @(posedge mclk)
  begin
    irq_ack <= service_req ? pending : '0;
    if (!core_reset_n || cpu_halt || pc_load)
    begin
      fetch_valid <= 1'b0;
      fetch_addr  <= ~fetch_addr;
      if (pc_load)
        pc_q <= START;
    end
    else
    begin
      fetch_valid <= 1'b1;
      fetch_addr  <= jump ? jump_addr : pc_q;
      pc_q        <= (jump ? jump_addr : pc_q) + 20'h00001;
    end
  end

  assign resume_pc = pc_q + 20'h00002;
endmodule

// File: dv/tb.sv
// Testbench for the idle mode and reset control block
`timescale 1ns/1ps
module tb;
  logic            mclk, rst_n, avs_read, avs_write, avs_wait, fv, wdt_req, jump;
  logic            core_n, pc_load, halt, wdt_halt, svc, master_en, jump_flag, nest, wen;
  logic [7:0]      avs_address, presc, p;
  logic [31:0]     avs_writedata, avs_readdata, rd;
  logic [19:0]     fa, resume_pc, jump_addr, snap, pc_value;
  logic [15:0]     irq_set, irq_ack, ien, latch;
  logic [3:0]      bank;
  int              error_cnt, checks_done;

  imrc_top #(.HOLD(4)) i_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_wait), .fetch_valid(fv),
    .fetch_addr(fa), .resume_pc(resume_pc), .irq_set(irq_set), .irq_ack(irq_ack),
    .wdt_reset_req(wdt_req), .core_reset_n_q(core_n), .pc_load_q(pc_load),
    .pc_value_q(pc_value), .cpu_halt_q(halt), .wdt_halt_q(wdt_halt), .service_req_q(svc),
    .interrupt_master_enable_flag_q(master_en), .individual_interrupt_enable_q(ien),
    .interrupt_request_latch_q(latch), .jump_status_flag_q(jump_flag),
    .register_bank_selector_q(bank), .interrupt_nesting_flag_q(nest),
    .wdt_enable_q(wen), .prescaler_q(presc));

  imrc_cpu_model i_cpu (.mclk(mclk), .core_reset_n(core_n), .cpu_halt(halt),
    .pc_load(pc_load), .service_req(svc), .pending(latch & ien), .jump(jump),
    .jump_addr(jump_addr), .fetch_valid(fv), .fetch_addr(fa), .resume_pc(resume_pc),
    .irq_ack(irq_ack));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One Avalon-MM transfer, held until waitrequest is sampled low
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read      <= !w;
    avs_write     <= w;
    avs_address   <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_wait !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    cmp("bus answer", 1, n < 20);
  endtask

  task automatic chk_init();
    cmp("jump flag", 1, jump_flag);
    cmp("master enable", 0, master_en);
    cmp("enables", 0, ien);
    cmp("bank", 0, bank);
    cmp("nesting", 0, nest);
    cmp("watchdog enable", 1, wen);
  endtask

  task automatic wait_load();
    repeat (40)
    begin
      step(1);
      if (pc_load === 1'b1)
        break;
    end
    cmp("vector load", 1, pc_load);
    cmp("vector", 32'h000FFFFC, pc_value);
    cmp("core running", 1, core_n);
    chk_init();
  endtask

  task automatic pin_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    step(12);
    cmp("core reset", 0, core_n);
    cmp("halt in reset", 0, halt);
    cmp("prescaler", 0, presc);
    @(posedge mclk);
    rst_n <= 1'b1;
    wait_load();
  endtask

  task automatic int_reset(int c);
    repeat (6)
    begin
      step(1);
      if (core_n === 1'b0)
        break;
    end
    cmp("internal reset", 0, core_n);
    wait_load();
    bus(0, imrc_pkg::OFS_STATUS, 0);
    cmp("cause", 32'h1 << (imrc_pkg::STAT_CAUSE_LSB + c), rd & 32'h00000070);
  endtask

  task automatic jump_to(logic [19:0] a);
    @(posedge mclk);
    jump      <= 1'b1;
    jump_addr <= a;
    @(posedge mclk);
    jump <= 1'b0;
  endtask

  task automatic t_idle(logic m);
    bus(1, imrc_pkg::OFS_INT_EN, {m, 27'h0, 4'h8});
    bus(1, imrc_pkg::OFS_CTRL, 32'h000000A0);
    snap = resume_pc;
    #1;
    cmp("cpu halt", 1, halt);
    cmp("wdt halt", 1, wdt_halt);
    cmp("held pc", snap, pc_value);
    p = presc;
    step(3);
    cmp("prescaler runs", 1, presc != p);
    bus(1, imrc_pkg::OFS_INT_EN, 0);
    cmp("enables kept", 16'h0008, ien);
    bus(0, imrc_pkg::OFS_STATUS, 0);
    cmp("idle status set", 1, rd[0]);
    @(posedge mclk);
    irq_set <= 16'h0008;
    @(posedge mclk);
    irq_set <= 16'h0000;
    repeat (8)
    begin
      step(1);
      if (halt === 1'b0)
        break;
    end
    cmp("woken", 0, halt);
    cmp("wdt resumed", 0, wdt_halt);
    cmp("service", m, svc);
    bus(0, imrc_pkg::OFS_CTRL, 0);
    cmp("idle bit", 0, rd[5]);
    bus(0, imrc_pkg::OFS_STATUS, 0);
    cmp("idle status", 0, rd[0]);
  endtask

  task automatic t_wake_plain();
    t_idle(1'b0);
    step(4);
    cmp("latch kept", 1, latch[3]);
    bus(1, imrc_pkg::OFS_LATCH, 0);
    step(1);
    cmp("latch cleared", 0, latch[3]);
  endtask

  task automatic t_pin_idle();
    bus(1, imrc_pkg::OFS_CTRL, 32'h000000A0);
    pin_reset();
    bus(0, imrc_pkg::OFS_CTRL, 0);
    cmp("normal after reset", 0, rd[5]);
  endtask

  task automatic t_trap();
    bus(1, imrc_pkg::OFS_INT_EN, 32'h80000001);
    jump_to(20'h01000);
    step(6);
    cmp("no trap past area", 1, core_n);
    jump_to(20'h00FFF);
    int_reset(imrc_pkg::CAUSE_TRAP);
    bus(1, imrc_pkg::OFS_TRAP_SEL, 1);
    bus(1, imrc_pkg::OFS_TRAP_KEY, 32'h000000A5);
    bus(0, imrc_pkg::OFS_TRAP_KEY, 0);
    cmp("trap key read", 0, rd);
    bus(0, 8'h3C, 0);
    cmp("unmapped read", 0, rd);
    jump_to(20'h00010);
    step(8);
    cmp("ram fetch runs", 1, core_n);
    jump_to(20'h10000);
  endtask

  task automatic t_internal();
    bus(1, imrc_pkg::OFS_INT_EN, 32'h80000001);
    bus(1, imrc_pkg::OFS_CORE, 32'h0000002F);
    bus(0, imrc_pkg::OFS_CORE, 0);
    cmp("core flags", 32'h0000002F, rd);
    @(posedge mclk);
    wdt_req <= 1'b1;
    @(posedge mclk);
    wdt_req <= 1'b0;
    int_reset(imrc_pkg::CAUSE_WDT);
    bus(1, imrc_pkg::OFS_CTRL, 32'h00000000);
    int_reset(imrc_pkg::CAUSE_CLOCK);
    bus(1, imrc_pkg::OFS_CTRL, 32'h000000C0);
    int_reset(imrc_pkg::CAUSE_CLOCK);
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    close_out();
  end

  initial
  begin
    {rst_n, avs_read, avs_write, wdt_req, jump} = 5'h00;
    {avs_address, avs_writedata, jump_addr, irq_set} = '0;
    pin_reset();
    t_wake_plain();
    t_idle(1'b1);
    t_pin_idle();
    t_trap();
    t_internal();
    close_out();
  end
endmodule
